// ### verilog/spd_pkg.sv
// shared constants, command codes and carriers for the sdram pin command decoder
package spd_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W  = 15;
    localparam int BANK_W  = 3;
    localparam int BANKS   = 8;
    localparam int COL_W   = 11;
    localparam int MR_NUM  = 4;

    // ------------------------------------------------------------
    // address qualifier bit positions
    // ------------------------------------------------------------
    localparam int AUTOCLOSE_SELECT_BIT   = 10;
    localparam int BURST_HALVE_SELECT_BIT = 12;
    localparam int NARROW_COL_HI_BIT      = 11;
    localparam int COL_LOW_TOP            = 9;

    // ------------------------------------------------------------
    // mode register fields used by the decoder
    // ------------------------------------------------------------
    localparam logic [1:0] MR_SEL_ZERO          = 2'h0;
    localparam logic [1:0] MR_SEL_ONE           = 2'h1;
    localparam int         MR0_BURST_LO         = 0;
    localparam int         MR0_BURST_HI         = 1;
    localparam logic [1:0] BURST_FIXED_FULL     = 2'h0;
    localparam logic [1:0] BURST_OTF            = 2'h1;
    localparam logic [1:0] BURST_FIXED_CHOP     = 2'h2;
    localparam int         MR1_TERM_STROBE_BIT  = 11;
    localparam int         MR1_RTT_B0           = 2;
    localparam int         MR1_RTT_B1           = 6;
    localparam int         MR1_RTT_B2           = 9;
    localparam logic [14:0] MR_RESET_VALUE      = 15'h0000;

    // ------------------------------------------------------------
    // burst lengths in beats, full and chopped
    // ------------------------------------------------------------
    localparam logic [3:0] BEATS_FULL  = 4'h8;
    localparam logic [3:0] BEATS_CHOP  = 4'h4;

    // ------------------------------------------------------------
    // decoded commands and power states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        deselect_cmd, idle_cmd, mode_register_load, refresh_cmd, self_refresh_entry_cmd,
        self_refresh_exit_cmd, bank_close_cmd, all_bank_close, row_open_cmd, write_cmd,
        read_cmd, impedance_cal_long, impedance_cal_short, powerdown_entry_cmd,
        powerdown_exit_cmd
    } spd_cmd_e;

    typedef enum logic [1:0] {
        PWR_ACTIVE, PWR_PD_PRECHARGE, PWR_PD_ACTIVE, PWR_SELF_REFRESH
    } spd_pwr_e;

    // pins as seen at the command/address ball group
    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              cke;
        logic              termination_enable_input;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } spd_pins_s;

    // one decoded command handed to the array side
    typedef struct packed {
        spd_cmd_e          cmd;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] row;
        logic [COL_W-1:0]  col;
        logic              autoclose;
        logic              chopped;
        logic [1:0]        mr_sel;
    } spd_cmd_s;
endpackage

// ### verilog/spd_decode.sv
// command and pin-function decoder with two-entry output buffer
`timescale 1ns/1ps
module spd_decode (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // command/address pins and organisation strap
    input  wire spd_pkg::spd_pins_s pins,
    input  wire logic              org_wide,
    // write data beat: mask sampled with each beat
    input  wire logic              wr_beat_valid,
    input  wire logic              write_mask,
    // decoded command stream
    output logic                   cmd_valid,
    input  wire logic              cmd_ready,
    output spd_pkg::spd_cmd_s      cmd_out,
    output logic                   cmd_accept_ready,
    // array write strobe
    output logic                   array_write_en,
    // strobe and pin functions
    output logic                   strobe_oe,
    output logic                   termination_on,
    output logic                   termination_strobe,
    // input buffer enables and power state
    output logic                   clk_buf_en,
    output logic                   term_buf_en,
    output logic                   cmd_buf_en,
    output spd_pkg::spd_pwr_e      power_state,
    output logic [spd_pkg::BANKS-1:0] bank_open
);
    import spd_pkg::*;

    // ------------------------------------------------------------
    // input capture
    // ------------------------------------------------------------
    spd_pins_s pins_m_q;
    spd_pins_s pins_q;
    logic      cke_prev_q;
    logic      org_m_q;
    logic      org_q;
    logic      beat_m_q;
    logic      beat_q;
    logic      mask_m_q;
    logic      mask_q;

    // two flops on every pin before decode; the whole bundle moves together
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pins_m_q   <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            pins_q     <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
            cke_prev_q <= 1'b0;
        end else begin
            pins_m_q   <= pins;
            pins_q     <= pins_m_q;
            cke_prev_q <= pins_q.cke;
        end
    end

    // strap and data-side sampling
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            org_m_q  <= 1'b0;
            org_q    <= 1'b0;
            beat_m_q <= 1'b0;
            beat_q   <= 1'b0;
            mask_m_q <= 1'b0;
            mask_q   <= 1'b0;
        end else begin
            org_m_q  <= org_wide;
            org_q    <= org_m_q;
            beat_m_q <= wr_beat_valid;
            beat_q   <= beat_m_q;
            mask_m_q <= write_mask;
            mask_q   <= mask_m_q;
        end
    end

    // ------------------------------------------------------------
    // mode registers
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] mode_reg_q [MR_NUM];
    logic [ADDR_W-1:0] mode_register_one;
    logic [1:0]        burst_mode;
    logic              term_disabled;
    assign mode_register_one = mode_reg_q[MR_SEL_ONE];
    assign burst_mode = mode_reg_q[MR_SEL_ZERO][MR0_BURST_HI:MR0_BURST_LO];
    assign term_disabled = ~(mode_register_one[MR1_RTT_B0] | mode_register_one[MR1_RTT_B1]
                             | mode_register_one[MR1_RTT_B2]);
    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    spd_pwr_e pwr_q;
    spd_cmd_s dec;
    logic     dec_push;
    logic     is_idle_code;
    // idle code: chip deselected, or selected with all strobes high
    assign is_idle_code = pins_q.cs_n | (pins_q.ras_n & pins_q.cas_n & pins_q.we_n);

    always_comb begin
        dec           = '0;
        dec.cmd       = deselect_cmd;
        dec.bank      = pins_q.bank;
        dec.row       = pins_q.addr;
        dec.col       = {pins_q.addr[NARROW_COL_HI_BIT] & ~org_q,
                         pins_q.addr[COL_LOW_TOP:0]};
        dec.mr_sel    = pins_q.bank[1:0];
        dec.autoclose = pins_q.addr[AUTOCLOSE_SELECT_BIT];
        case (burst_mode)
            BURST_OTF:        dec.chopped = ~pins_q.addr[BURST_HALVE_SELECT_BIT];
            BURST_FIXED_CHOP: dec.chopped = 1'b1;
            default:          dec.chopped = 1'b0;
        endcase
        if (pwr_q != PWR_ACTIVE) begin
            // only an exit is heard while powered down
            if (pins_q.cke && is_idle_code) begin
                dec.cmd = (pwr_q == PWR_SELF_REFRESH) ? self_refresh_exit_cmd
                                                      : powerdown_exit_cmd;
            end else begin
                dec.cmd = deselect_cmd;
            end
        end else if (!cke_prev_q) begin
            dec.cmd = deselect_cmd;
        end else if (pins_q.cs_n) begin
            dec.cmd = pins_q.cke ? deselect_cmd : powerdown_entry_cmd;
        end else begin
            case ({pins_q.ras_n, pins_q.cas_n, pins_q.we_n})
                3'b000: dec.cmd = pins_q.cke ? mode_register_load : deselect_cmd;
                3'b001: dec.cmd = pins_q.cke ? refresh_cmd : self_refresh_entry_cmd;
                3'b010: begin
                    // precharge; a lone bank with no open row is just idle
                    if (pins_q.addr[AUTOCLOSE_SELECT_BIT]) begin
                        dec.cmd = all_bank_close;
                    end else if (bank_open[pins_q.bank]) begin
                        dec.cmd = bank_close_cmd;
                    end else begin
                        dec.cmd = idle_cmd;
                    end
                end
                3'b011: dec.cmd = row_open_cmd;
                3'b100: dec.cmd = write_cmd;
                3'b101: dec.cmd = read_cmd;
                3'b110: dec.cmd = pins_q.addr[AUTOCLOSE_SELECT_BIT]
                                  ? impedance_cal_long : impedance_cal_short;
                default: dec.cmd = pins_q.cke ? idle_cmd : powerdown_entry_cmd;
            endcase
            // only self-refresh and power-down entry are legal codes with cke dropping
            if (!pins_q.cke && !(dec.cmd inside {self_refresh_entry_cmd,
                                                 powerdown_entry_cmd})) begin
                dec.cmd = deselect_cmd;
            end
        end
    end

    // deselects carry nothing for the array, so they are not queued
    assign dec_push = (dec.cmd != deselect_cmd);

    // ------------------------------------------------------------
    // power state and bank tracking
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pwr_q <= PWR_ACTIVE;
        end else begin
            case (dec.cmd)
                self_refresh_entry_cmd: pwr_q <= PWR_SELF_REFRESH;
                powerdown_entry_cmd:    pwr_q <= (|bank_open) ? PWR_PD_ACTIVE
                                                              : PWR_PD_PRECHARGE;
                self_refresh_exit_cmd,
                powerdown_exit_cmd:     pwr_q <= PWR_ACTIVE;
                default:                pwr_q <= pwr_q;
            endcase
        end
    end

    // open-row map; auto precharge closes the bank at the command, latency ignored
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bank_open <= '0;
        end else begin
            case (dec.cmd)
                row_open_cmd:   bank_open[dec.bank] <= 1'b1;
                bank_close_cmd: bank_open[dec.bank] <= 1'b0;
                all_bank_close: bank_open <= '0;
                read_cmd, write_cmd: begin
                    if (dec.autoclose) begin
                        bank_open[dec.bank] <= 1'b0;
                    end
                end
                default: bank_open <= bank_open;
            endcase
        end
    end

    // mode register image, loaded from the address op-code
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < MR_NUM; i++) begin
                mode_reg_q[i] <= MR_RESET_VALUE;
            end
        end else if (dec.cmd == mode_register_load) begin
            mode_reg_q[dec.mr_sel] <= pins_q.addr;
        end
    end

    // ------------------------------------------------------------
    // two-entry output buffer
    // ------------------------------------------------------------
    spd_cmd_s   buf_q [2];
    logic [1:0] count_q;
    logic       pop;
    logic       push_ok;

    assign cmd_accept_ready = (count_q != 2'h2);
    assign pop              = cmd_valid & cmd_ready;
    assign push_ok          = dec_push & (cmd_accept_ready | pop);
    assign cmd_valid        = (count_q != 2'h0);
    assign cmd_out          = buf_q[0];

    // a full buffer with no drain loses the new word; cmd_accept_ready warns first
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            count_q  <= 2'h0;
        end else begin
            case ({push_ok, pop})
                2'b10: begin
                    buf_q[count_q[0]] <= dec;
                    count_q           <= count_q + 2'h1;
                end
                2'b01: begin
                    buf_q[0] <= buf_q[1];
                    count_q  <= count_q - 2'h1;
                end
                2'b11: begin
                    if (count_q == 2'h1) begin
                        buf_q[0] <= dec;
                    end else begin
                        buf_q[0] <= buf_q[1];
                        buf_q[1] <= dec;
                    end
                end
                default: count_q <= count_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // data side: mask, strobe direction, pin functions
    // ------------------------------------------------------------
    logic [3:0] strobe_cnt_q;
    logic       write_open_q;

    // a write window is open from the write command until the next read, precharge, self-refresh or power-down entry
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            write_open_q <= 1'b0;
        end else if (dec.cmd == write_cmd) begin
            write_open_q <= 1'b1;
        end else if (dec.cmd inside {read_cmd, bank_close_cmd, all_bank_close,
                                     self_refresh_entry_cmd, powerdown_entry_cmd}) begin
            write_open_q <= 1'b0;
        end
    end

    // masked beats never reach the array unless termination_strobe is set
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            array_write_en <= 1'b0;
        end else begin
            array_write_en <= write_open_q & beat_q & ~(mask_q & ~termination_strobe);
        end
    end

    // device drives the strobe for half the read beats in clocks (two beats per clock)
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            strobe_cnt_q <= 4'h0;
        end else if (dec.cmd == read_cmd) begin
            strobe_cnt_q <= (dec.chopped ? BEATS_CHOP : BEATS_FULL) >> 1;
        end else if (strobe_cnt_q != 4'h0) begin
            strobe_cnt_q <= strobe_cnt_q - 4'h1;
        end
    end

    // registered pin-function outputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            strobe_oe          <= 1'b0;
            termination_on     <= 1'b0;
            termination_strobe <= 1'b0;
        end else begin
            strobe_oe          <= (strobe_cnt_q != 4'h0);
            termination_on     <= pins_q.termination_enable_input & ~term_disabled
                                  & (pwr_q != PWR_SELF_REFRESH);
            termination_strobe <= org_q & mode_register_one[MR1_TERM_STROBE_BIT];
        end
    end

    // buffer enables follow the power state
    assign clk_buf_en  = (pwr_q != PWR_SELF_REFRESH);
    assign term_buf_en = (pwr_q != PWR_SELF_REFRESH);
    assign cmd_buf_en  = (pwr_q == PWR_ACTIVE);
    assign power_state = pwr_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_cs_masks: assert property (@(posedge clock) disable iff (!resetn)
        (pins_q.cs_n && pins_q.cke && cke_prev_q && pwr_q == PWR_ACTIVE)
        |-> dec.cmd == deselect_cmd)
        else $error("command taken while chip select high");
    a_pd_entry: assert property (@(posedge clock) disable iff (!resetn)
        (dec.cmd == powerdown_entry_cmd && bank_open == '0) |=> pwr_q == PWR_PD_PRECHARGE)
        else $error("idle power-down entry not taken");
    a_pd_active: assert property (@(posedge clock) disable iff (!resetn)
        (dec.cmd == powerdown_entry_cmd && bank_open != '0) |=> pwr_q == PWR_PD_ACTIVE)
        else $error("active power-down entry not taken");
    a_sr_buffers: assert property (@(posedge clock) disable iff (!resetn)
        pwr_q == PWR_SELF_REFRESH |-> !clk_buf_en && !term_buf_en && !cmd_buf_en)
        else $error("buffers left on in self-refresh");
    a_sr_exit: assert property (@(posedge clock) disable iff (!resetn)
        (pwr_q == PWR_SELF_REFRESH && pins_q.cke && pins_q.cs_n) |=> pwr_q == PWR_ACTIVE)
        else $error("self-refresh exit missed");
    a_mask_drop: assert property (@(posedge clock) disable iff (!resetn)
        (mask_q && !termination_strobe) |=> !array_write_en)
        else $error("masked beat written");
    // strobe is high on the second and third edges after a chopped read, low on the fourth
    a_strobe_len: assert property (@(posedge clock) disable iff (!resetn)
        (dec.cmd == read_cmd && dec.chopped) ##1 (dec.cmd != read_cmd) [*2]
        |-> strobe_oe ##1 strobe_oe ##1 !strobe_oe)
        else $error("chopped read strobe length wrong");
    a_pre_idle: assert property (@(posedge clock) disable iff (!resetn)
        (dec.cmd == idle_cmd && !pins_q.ras_n) |-> !bank_open[pins_q.bank])
        else $error("open bank precharge dropped");
    a_bank_close: assert property (@(posedge clock) disable iff (!resetn)
        dec.cmd == all_bank_close |=> bank_open == '0)
        else $error("all-bank close left a row open");
    a_mr_load: assert property (@(posedge clock) disable iff (!resetn)
        dec.cmd == mode_register_load |=> mode_reg_q[$past(dec.mr_sel)] == $past(pins_q.addr))
        else $error("mode register not loaded");
    a_term_gate: assert property (@(posedge clock) disable iff (!resetn)
        term_disabled |=> !termination_on)
        else $error("termination on while disabled");
endmodule

// ### testbench/spd_ctrl_model.sv
// controller-side model driving command pins and write beats
`timescale 1ns/1ps
module spd_ctrl_model (
    // clock
    input  wire logic          clock,
    // driven pins and write beats
    output spd_pkg::spd_pins_s pins,
    output logic               wr_beat_valid,
    output logic               write_mask
);
    import spd_pkg::*;
    logic term = 1'b0; // termination request level
    // idle: deselected, clock enable high
    initial begin
        pins = {4'hf, 1'b1, 1'b0, 3'h0, 15'h0000};
        wr_beat_valid = 1'b0;
        write_mask = 1'b0;
    end
    // one command for one clock, then lines released to a deselect
    task automatic issue(input logic [3:0] c, input logic ck, input logic [2:0] b,
                         input logic [14:0] a);
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = c;
        pins.cke = ck; // held until the next command
        pins.bank = b;
        pins.addr = a; // qualifiers always defined
        pins.termination_enable_input = term;
        @(posedge clock);
        #1;
        pins.cs_n = 1'b1;
        pins.bank = ~b; // released lines show no stale value
        pins.addr = ~a;
    endtask
    // one write beat per clock; strobe timing is ours
    // back-to-back beats keep valid up, so no line is written twice in one step
    task automatic beats(input logic [1:0] m);
        for (int i = 0; i < 2; i++) begin
            wr_beat_valid = 1'b1;
            write_mask = m[i];
            @(posedge clock);
            #1;
        end
        wr_beat_valid = 1'b0;
        write_mask = ~m[1];
    endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the sdram pin command decoder
`timescale 1ns/1ps
module testbench;
    import spd_pkg::*;
    logic      clock, resetn, org_wide, wr_beat_valid, write_mask, cmd_valid, cmd_ready;
    logic      cmd_accept_ready, array_write_en, strobe_oe, termination_on;
    logic      termination_strobe, clk_buf_en, term_buf_en, cmd_buf_en;
    logic [7:0] bank_open;
    spd_pins_s pins;
    spd_cmd_s  cmd_out;
    spd_pwr_e  power_state;
    spd_cmd_s  got[$];
    int        fails = 0, num_checks = 0, we_cnt = 0, oe_cnt = 0;

    spd_decode dut (.clock, .resetn, .pins, .org_wide, .wr_beat_valid, .write_mask,
        .cmd_valid, .cmd_ready, .cmd_out, .cmd_accept_ready, .array_write_en, .strobe_oe,
        .termination_on, .termination_strobe, .clk_buf_en, .term_buf_en, .cmd_buf_en,
        .power_state, .bank_open);
    spd_ctrl_model ctl (.clock, .pins, .wr_beat_valid, .write_mask);

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // collect popped commands and count strobe cycles
    always @(posedge clock) begin
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1) got.push_back(cmd_out);
        we_cnt += (array_write_en === 1'b1);
        oe_cnt += (strobe_oe === 1'b1);
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one command, then long enough for decode, queue and strobes
    task automatic run(input logic [3:0] c, input logic ck, input logic [2:0] b,
                       input logic [14:0] a);
        got.delete();
        ctl.issue(c, ck, b, a);
        repeat (7) @(posedge clock);
        #1;
    endtask
    task automatic expect_cmd(input spd_cmd_e e);
        check(got.size(), 1);
        check(got[0].cmd, e);
    endtask
    // watchdog: the sequence needs well under 1000 clocks
    initial begin
        #5000;
        fails++;
        give_verdict();
    end
    initial begin
        resetn = 1'b0;
        cmd_ready = 1'b1;
        org_wide = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        resetn = 1'b1;
        check(power_state, PWR_ACTIVE);
        check({cmd_valid, cmd_accept_ready, bank_open}, 10'h100);
        // let cke reach the decode stage so reset alone cannot mask the next code
        repeat (2) @(posedge clock);
        #1;
        run(4'h8, 1'b1, 3'h0, 15'h0000);
        check(got.size(), 0); // strobes low but unselected
        run(4'h0, 1'b1, 3'h0, 15'h0001);
        expect_cmd(mode_register_load);
        run(4'h0, 1'b1, 3'h1, 15'h0804);
        check(got[0].mr_sel, 2'h1);
        check(termination_strobe, 1'b1);
        run(4'h0, 1'b1, 3'h1, 15'h0004);
        check(termination_strobe, 1'b0);
        ctl.term = 1'b1;
        run(4'h7, 1'b1, 3'h0, 15'h0000);
        expect_cmd(idle_cmd);
        check(termination_on, 1'b1);
        run(4'h3, 1'b1, 3'h5, 15'h7abc);
        check({got[0].bank, got[0].row}, {3'h5, 15'h7abc});
        run(4'h3, 1'b1, 3'h2, 15'h0123);
        check(bank_open, 8'h24);
        oe_cnt = 0;
        run(4'h5, 1'b1, 3'h5, 15'h0d55);
        expect_cmd(read_cmd);
        check(got[0].col, 11'h155); // wide: bit 11 not a column bit
        check({got[0].autoclose, got[0].chopped}, 2'h3);
        check(oe_cnt, 2);
        check(bank_open, 8'h04);
        org_wide = 1'b0;
        run(4'h4, 1'b1, 3'h2, 15'h18aa);
        expect_cmd(write_cmd);
        check({got[0].autoclose, got[0].chopped, got[0].col[9:0]}, 12'h0aa);
        check(got[0].col, 11'h4aa); // narrow: bit 11 joins the column
        we_cnt = 0;
        ctl.beats(2'b10);
        repeat (5) @(posedge clock);
        #1;
        check(we_cnt, 1);
        run(4'h7, 1'b0, 3'h0, 15'h0000);
        check(power_state, PWR_PD_ACTIVE);
        check({clk_buf_en, term_buf_en, cmd_buf_en}, 3'h6);
        run(4'h7, 1'b1, 3'h0, 15'h0000);
        check(power_state, PWR_ACTIVE);
        run(4'h2, 1'b1, 3'h2, 15'h0000);
        expect_cmd(bank_close_cmd);
        run(4'h2, 1'b1, 3'h0, 15'h0400);
        expect_cmd(all_bank_close);
        run(4'h2, 1'b1, 3'h3, 15'h0000);
        expect_cmd(idle_cmd);
        run(4'h1, 1'b1, 3'h0, 15'h0000);
        expect_cmd(refresh_cmd);
        run(4'h6, 1'b1, 3'h0, 15'h0400);
        expect_cmd(impedance_cal_long);
        run(4'h6, 1'b1, 3'h0, 15'h0000);
        expect_cmd(impedance_cal_short);
        run(4'h1, 1'b0, 3'h0, 15'h0000);
        check(power_state, PWR_SELF_REFRESH);
        check({clk_buf_en, term_buf_en, cmd_buf_en}, 3'h0);
        check(termination_on, 1'b0);
        run(4'hf, 1'b1, 3'h0, 15'h0000);
        check(power_state, PWR_ACTIVE);
        check(termination_on, 1'b1);
        run(4'h0, 1'b1, 3'h1, 15'h0000);
        check(termination_on, 1'b0);
        // fixed chopped burst: bit 12 high must not lengthen the read
        run(4'h0, 1'b1, 3'h0, 15'h0002);
        oe_cnt = 0;
        run(4'h5, 1'b1, 3'h0, 15'h1000);
        check({got[0].cmd, got[0].chopped}, {read_cmd, 1'b1});
        check(oe_cnt, 2);
        // receiver stalls: third word is refused, two survive
        cmd_ready = 1'b0;
        repeat (3) run(4'h7, 1'b1, 3'h0, 15'h0000);
        check(cmd_accept_ready, 1'b0);
        cmd_ready = 1'b1;
        repeat (4) @(posedge clock);
        check(got.size(), 2);
        give_verdict();
    end
endmodule
